// ===== core/brr_pkg.sv
// Constants for the branch record control block.
// Assumes a 200 MHz core clock and retirement events presented one per cycle.
package brr_pkg;
	localparam int ADDR_W = 64;            // Stored address width
	localparam int LIN_W = 48;             // Implemented linear address bits
	localparam int DEPTH = 8;              // Entry storage slots
	localparam int IDX_W = 3;              // Entry index width
	localparam int INFO_W = 64;            // Info register width
	localparam logic [INFO_W-1:0] INFO_DEF_MASK = 64'hf000_0000_0000_ffff; // Defined info bits
	localparam int CTL_W = 32;             // Control register width
	localparam int CTL_EN_BIT = 0;         // Enable bit position
	localparam logic [CTL_W-1:0] CTL_RST = 32'h0000_0000;
	localparam logic [4:0] DEPTH_RST = 5'h08; // Depth after initialisation
	localparam int CFG_EMBED_BIT = 3;      // Sample config embed bit
	localparam int CFG_CNT_LO = 24;        // Sample config count field
	localparam int CFG_CNT_HI = 28;
	localparam int ENTRY_BYTES = 24;       // Bytes per embedded entry
	localparam logic [5:0] FMT_ABSENT = 6'h3f; // Format code with no records
	localparam logic [15:0] SIZE_BASE = 16'h0030; // Sample record base size
	typedef enum logic [2:0] {
		BRR_W_FROM = 3'h0,
		BRR_W_TO = 3'h1,
		BRR_W_INFO = 3'h2,
		BRR_W_LER_FROM = 3'h3,
		BRR_W_LER_TO = 3'h4,
		BRR_W_LER_INFO = 3'h5,
		BRR_W_CTL = 3'h6,
		BRR_W_DEPTH = 3'h7
	} brr_wsel_t;
	// Sign extend from the top implemented linear bit
	function automatic logic [ADDR_W-1:0] brr_canon(input logic [ADDR_W-1:0] a);
		brr_canon = {{(ADDR_W-LIN_W){a[LIN_W-1]}}, a[LIN_W-1:0]};
	endfunction
endpackage

// ===== core/brr_ctrl.sv
// Branch record control: enable handling, entry store, sampling clamp, trace store.
// Assumes all event strobes are single-cycle and synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module brr_ctrl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Processor events
	input wire logic warm_reset_i,
	input wire logic in_deep_idle_i,
	input wire logic debug_exception_i,
	input wire logic secure_launch_i,
	input wire logic monitor_wait_deep_i,
	input wire logic monitor_wait_clear_i,
	input wire logic sys_mgmt_enter_i,
	input wire logic resume_sys_mgmt_i,
	input wire logic perf_irq_pending_i,
	input wire logic freeze_clear_i,
	input wire logic freeze_on_perf_interrupt_i,
	input wire logic arch_records_i,
	// Retired branch
	input wire logic retire_i,
	input wire logic retire_zero_disp_call_i,
	input wire logic [brr_pkg::ADDR_W-1:0] retire_from_i,
	input wire logic [brr_pkg::ADDR_W-1:0] retire_to_i,
	input wire logic [brr_pkg::INFO_W-1:0] retire_info_i,
	// Register writes and reads
	input wire logic wr_i,
	input wire logic [2:0] wr_sel_i,
	input wire logic [brr_pkg::IDX_W-1:0] wr_idx_i,
	input wire logic [brr_pkg::ADDR_W-1:0] wr_data_i,
	input wire logic dbg_bit0_wr_i,
	input wire logic [brr_pkg::IDX_W-1:0] rd_idx_i,
	// Sample record configuration
	input wire logic [31:0] sample_record_config_i,
	// Register contents
	output logic [brr_pkg::CTL_W-1:0] branch_record_control_o,
	output logic [4:0] branch_record_depth_o,
	output logic branch_record_freeze_o,
	output logic [brr_pkg::ADDR_W-1:0] rd_from_o,
	output logic [brr_pkg::ADDR_W-1:0] rd_to_o,
	output logic [brr_pkg::INFO_W-1:0] rd_info_o,
	output logic [brr_pkg::ADDR_W-1:0] ler_from_o,
	output logic dbg_bit0_o,
	output logic [5:0] record_format_code_o,
	output logic wr_fault_o,
	// Sampled record shape
	output logic sample_embed_o,
	output logic [4:0] sampled_entry_count_o,
	output logic [15:0] sample_size_o,
	// Branch trace store
	output logic trace_valid_o,
	output logic [brr_pkg::ADDR_W-1:0] trace_from_o,
	output logic [brr_pkg::ADDR_W-1:0] trace_to_o
);
	import brr_pkg::*;

	// Architectural state
	logic [CTL_W-1:0] ctl_ff, nxt_ctl;
	logic [4:0] depth_ff, nxt_depth;
	logic frz_ff, nxt_frz;
	logic smm_save_ff, nxt_smm_save; // Enable saved on sys-mgmt entry
	logic [ADDR_W-1:0] from_ff [DEPTH];
	logic [ADDR_W-1:0] to_ff [DEPTH];
	logic [INFO_W-1:0] info_ff [DEPTH];
	logic [ADDR_W-1:0] nxt_from [DEPTH];
	logic [ADDR_W-1:0] nxt_to [DEPTH];
	logic [INFO_W-1:0] nxt_info [DEPTH];
	logic [ADDR_W-1:0] ler_from_ff, nxt_ler_from, ler_to_ff, nxt_ler_to;
	logic [INFO_W-1:0] ler_info_ff, nxt_ler_info;
	logic dbg0_ff, nxt_dbg0;
	// Output staging
	logic [ADDR_W-1:0] rdf_ff, rdt_ff, trf_ff, trt_ff;
	logic [INFO_W-1:0] rdi_ff;
	logic trv_ff, nxt_trv, emb_ff, nxt_emb;
	logic [4:0] cnt_ff, nxt_cnt;
	logic [15:0] size_ff, nxt_size;
	logic [5:0] fmt_ff, nxt_fmt;
	logic [ADDR_W-1:0] nxt_rdf, nxt_rdt, nxt_trf, nxt_trt; // Staged read and trace values
	logic [INFO_W-1:0] nxt_rdi;
	logic dbgo_ff, nxt_dbgo; // Debug bit0 as software reads it
	logic flt_ff; // Write fault flag, never raised
	logic record_ok; // A retired branch is written
	logic init_all;  // Full reinitialisation
	logic [4:0] req_cnt;

	// Retirement qualification
	always_comb begin
		// Disabled, frozen and debug-triggered branches are not captured
		record_ok = retire_i && ctl_ff[CTL_EN_BIT] && !frz_ff && !debug_exception_i
			&& !secure_launch_i && !sys_mgmt_enter_i;
		init_all = !resetn_i || (warm_reset_i && in_deep_idle_i);
		req_cnt = sample_record_config_i[CFG_CNT_HI:CFG_CNT_LO];
	end

	// Control, depth, freeze next state
	always_comb begin
		nxt_ctl = ctl_ff;
		nxt_depth = depth_ff;
		nxt_frz = frz_ff;
		nxt_smm_save = smm_save_ff;
		nxt_dbg0 = dbg0_ff;
		if (wr_i && brr_wsel_t'(wr_sel_i) == BRR_W_CTL) begin
			nxt_ctl = wr_data_i[CTL_W-1:0];
		end
		if (wr_i && brr_wsel_t'(wr_sel_i) == BRR_W_DEPTH) begin
			nxt_depth = wr_data_i[4:0];
		end
		if (dbg_bit0_wr_i) begin
			nxt_dbg0 = wr_data_i[0];
		end
		if (resume_sys_mgmt_i) begin
			nxt_ctl[CTL_EN_BIT] = smm_save_ff;
		end
		if (sys_mgmt_enter_i) begin
			nxt_smm_save = ctl_ff[CTL_EN_BIT];
			nxt_ctl[CTL_EN_BIT] = 1'b0;
		end
		if (debug_exception_i) begin
			nxt_ctl[CTL_EN_BIT] = 1'b0;
		end
		if (secure_launch_i) begin
			nxt_ctl = CTL_RST;
		end
		// Freeze: set wins over clear
		if (freeze_clear_i) begin
			nxt_frz = 1'b0;
		end
		if (freeze_on_perf_interrupt_i && perf_irq_pending_i) begin
			nxt_frz = 1'b1;
		end
		if (warm_reset_i) begin
			nxt_ctl[CTL_EN_BIT] = 1'b0;
		end
		if (init_all) begin
			nxt_ctl = CTL_RST;
			nxt_depth = DEPTH_RST;
			nxt_frz = 1'b0;
			nxt_smm_save = 1'b0;
			nxt_dbg0 = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		ctl_ff <= nxt_ctl;
		depth_ff <= nxt_depth;
		frz_ff <= nxt_frz;
		smm_save_ff <= nxt_smm_save;
		dbg0_ff <= nxt_dbg0;
	end

	// Entry store next state; slot 0 is the newest entry
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			nxt_from[i] = from_ff[i];
			nxt_to[i] = to_ff[i];
			nxt_info[i] = info_ff[i];
		end
		nxt_ler_from = ler_from_ff;
		nxt_ler_to = ler_to_ff;
		nxt_ler_info = ler_info_ff;
		if (record_ok) begin
			for (int i = DEPTH-1; i > 0; i--) begin
				nxt_from[i] = from_ff[i-1];
				nxt_to[i] = to_ff[i-1];
				nxt_info[i] = info_ff[i-1];
			end
			nxt_from[0] = brr_canon(retire_from_i);
			nxt_to[0] = brr_canon(retire_to_i);
			nxt_info[0] = retire_info_i & INFO_DEF_MASK;
		end
		// Software writes never fault
		if (wr_i) begin
			case (brr_wsel_t'(wr_sel_i))
				BRR_W_FROM: nxt_from[wr_idx_i] = brr_canon(wr_data_i);
				BRR_W_TO: nxt_to[wr_idx_i] = brr_canon(wr_data_i);
				BRR_W_INFO: nxt_info[wr_idx_i] = wr_data_i & INFO_DEF_MASK;
				BRR_W_LER_FROM: nxt_ler_from = brr_canon(wr_data_i);
				BRR_W_LER_TO: nxt_ler_to = brr_canon(wr_data_i);
				BRR_W_LER_INFO: nxt_ler_info = wr_data_i & INFO_DEF_MASK;
				default: begin
				end
			endcase
		end
		// Deep idle wait zeroes entries only; shallow idle changes nothing
		if ((monitor_wait_deep_i && monitor_wait_clear_i) || init_all) begin
			for (int i = 0; i < DEPTH; i++) begin
				nxt_from[i] = '0;
				nxt_to[i] = '0;
				nxt_info[i] = '0;
			end
		end
		if (init_all) begin
			nxt_ler_from = '0;
			nxt_ler_to = '0;
			nxt_ler_info = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < DEPTH; i++) begin
			from_ff[i] <= nxt_from[i];
			to_ff[i] <= nxt_to[i];
			info_ff[i] <= nxt_info[i];
		end
		ler_from_ff <= nxt_ler_from;
		ler_to_ff <= nxt_ler_to;
		ler_info_ff <= nxt_ler_info;
	end

	// Sampled record shape and trace store
	always_comb begin
		nxt_emb = sample_record_config_i[CFG_EMBED_BIT];
		nxt_cnt = (req_cnt > depth_ff) ? depth_ff : req_cnt;
		nxt_size = SIZE_BASE;
		if (nxt_emb) begin
			nxt_size = SIZE_BASE + 16'(nxt_cnt) * 16'(ENTRY_BYTES);
		end
		// Copy newest entry on each retire that is not frozen or a zero-displacement call, even if not recorded
		nxt_trv = retire_i && !frz_ff && !retire_zero_disp_call_i;
		// Trace copies the fresh entry when it is written, else the stored newest one
		nxt_trf = record_ok ? brr_canon(retire_from_i) : from_ff[0];
		nxt_trt = record_ok ? brr_canon(retire_to_i) : to_ff[0];
		// Read port, one cycle behind the index
		nxt_rdf = from_ff[rd_idx_i];
		nxt_rdt = to_ff[rd_idx_i];
		nxt_rdi = info_ff[rd_idx_i];
		// Without model records the format is fixed and bit0 reads zero
		nxt_fmt = arch_records_i ? FMT_ABSENT : 6'h00;
		nxt_dbgo = nxt_dbg0 & ~arch_records_i;
		if (!resetn_i) begin
			nxt_trv = 1'b0;
			nxt_emb = 1'b0;
			nxt_cnt = '0;
			nxt_size = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		trv_ff <= nxt_trv;
		emb_ff <= nxt_emb;
		cnt_ff <= nxt_cnt;
		size_ff <= nxt_size;
		trf_ff <= nxt_trf;
		trt_ff <= nxt_trt;
		rdf_ff <= nxt_rdf;
		rdt_ff <= nxt_rdt;
		rdi_ff <= nxt_rdi;
		fmt_ff <= nxt_fmt;
		dbgo_ff <= nxt_dbgo;
		flt_ff <= 1'b0;
	end

	// Outputs
	assign branch_record_control_o = ctl_ff;
	assign branch_record_depth_o = depth_ff;
	assign branch_record_freeze_o = frz_ff;
	assign rd_from_o = rdf_ff;
	assign rd_to_o = rdt_ff;
	assign rd_info_o = rdi_ff;
	assign ler_from_o = ler_from_ff;
	assign dbg_bit0_o = dbgo_ff;
	assign record_format_code_o = fmt_ff;
	assign wr_fault_o = flt_ff;
	assign sample_embed_o = emb_ff;
	assign sampled_entry_count_o = cnt_ff;
	assign sample_size_o = size_ff;
	assign trace_valid_o = trv_ff;
	assign trace_from_o = trf_ff;
	assign trace_to_o = trt_ff;

	// Checks
	debug_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		debug_exception_i && !resume_sys_mgmt_i |=> !ctl_ff[CTL_EN_BIT]) else $error("enable kept after debug exception");
	launch_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		secure_launch_i && !wr_i |=> ctl_ff == CTL_RST) else $error("control not cleared on launch");
	warm_keep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		warm_reset_i && !in_deep_idle_i && !wr_i |=> !ctl_ff[CTL_EN_BIT] && depth_ff == $past(depth_ff))
		else $error("warm reset mishandled");
	warm_init_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		warm_reset_i && in_deep_idle_i |=> depth_ff == DEPTH_RST && from_ff[0] == '0) else $error("warm init incomplete");
	clamp_cnt_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		sampled_entry_count_o <= depth_ff || $past(depth_ff) != depth_ff) else $error("sample count not clamped");
	freeze_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		freeze_on_perf_interrupt_i && perf_irq_pending_i && !(warm_reset_i && in_deep_idle_i) |=> frz_ff)
		else $error("freeze not set");
	frozen_trace_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		frz_ff |=> !trace_valid_o) else $error("trace while frozen");
	zero_call_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		retire_zero_disp_call_i |=> !trace_valid_o) else $error("zero call traced");
	hold_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!ctl_ff[CTL_EN_BIT] && !wr_i && !monitor_wait_clear_i && !warm_reset_i |=> from_ff[1] == $past(from_ff[1]))
		else $error("entry moved while disabled");
	smm_restore_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		resume_sys_mgmt_i && !sys_mgmt_enter_i && !debug_exception_i && !warm_reset_i
		&& !secure_launch_i && !wr_i |=> ctl_ff[CTL_EN_BIT] == $past(smm_save_ff))
		else $error("enable not restored");
	trace_copy_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		retire_i && !frz_ff && !retire_zero_disp_call_i && !record_ok
		|=> trace_valid_o && trace_from_o == $past(from_ff[0])) else $error("trace copy wrong");
	size_base_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!sample_record_config_i[CFG_EMBED_BIT] |=> !sample_embed_o && sample_size_o == SIZE_BASE)
		else $error("entries embedded without request");
	cover_record_c: cover property (@(posedge clk_i) record_ok);
	cover_clamp_c: cover property (@(posedge clk_i) req_cnt > depth_ff && sample_record_config_i[CFG_EMBED_BIT]);
	cover_frz_c: cover property (@(posedge clk_i) $rose(frz_ff));
endmodule // brr_ctrl
`default_nettype wire

// ===== tb/brr_core_model.sv
// Core retirement model: presents one retired branch to the record block per request.
// Assumes the bench calls send at a falling edge of clk_i and nothing else drives these lines.
`timescale 1ns/1ps
`default_nettype none
module brr_core_model (
	// Clock
	input wire logic clk_i,
	// Retired branch
	output logic retire_o,
	output logic zero_disp_o,
	output logic [63:0] from_o,
	output logic [63:0] to_o,
	output logic [63:0] info_o
);
	// Idle at time zero
	initial begin
		retire_o = 1'b0;
		zero_disp_o = 1'b0;
		from_o = '0;
		to_o = '0;
		info_o = '0;
	end
	// Issues no state save or restore traffic, so no save image meets a restore area
	// Hold one retirement across a single rising edge, then scramble the released lines
	task automatic send(input logic [63:0] f, input logic [63:0] t, input logic zd);
		retire_o = 1'b1;
		zero_disp_o = zd;
		from_o = f;
		to_o = t;
		info_o = 64'h0000_0000_0000_0004;
		@(negedge clk_i);
		retire_o = 1'b0;
		zero_disp_o = 1'b0;
		from_o = ~f;
		to_o = ~t;
		info_o = ~info_o;
	endtask
endmodule // brr_core_model
`default_nettype wire

// ===== tb/tb.sv
// Bench for the branch record control block: sample shape table, then event cases by hand.
// Assumes brr_pkg and brr_core_model are compiled first; all controls are plain ports.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import brr_pkg::*;
	logic clk_i = 1'b0; // Core clock, 200 MHz
	logic resetn_i = 1'b0; // Full initialisation
	logic [8:0] ev = '0; // Event strobes, one bit each
	logic deep_idle = 1'b0, perf_irq = 1'b0, frz_on = 1'b0, arch = 1'b0; // Level inputs
	logic wr = 1'b0; // Register write strobe
	logic [2:0] sel = '0; // Register select
	logic [63:0] wdat = '0; // Write data
	logic [31:0] cfg = '0; // Sample record configuration
	logic retire, zdisp; // From the core model
	logic [63:0] rfrom, rto, rinfo;
	logic [31:0] ctl; // Observed outputs
	logic [4:0] depth, scnt;
	logic frz, dbg0, fault, emb, tv;
	logic [5:0] fmt;
	logic [15:0] ssize;
	logic [63:0] rdf, rdt, rdi, lerf, tf, tt;
	int n_errors = 0;
	int num_checks = 0;
	// Shape rows: config, embed, count, size
	logic [31:0] cfg_r [4] = '{32'h0400_0008, 32'h0800_0008, 32'h1f00_0008, 32'h0500_0000};
	logic emb_r [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
	logic [4:0] cnt_r [4] = '{5'h04, 5'h08, 5'h08, 5'h00};
	logic [15:0] size_r [4] = '{16'h0090, 16'h00f0, 16'h00f0, 16'h0030};
	localparam logic [63:0] a_src = 64'h0000_8000_0000_1234; // Not canonical
	localparam logic [63:0] a_can = 64'hffff_8000_0000_1234; // Its canonical form
	localparam logic [63:0] b_dst = 64'h0000_0000_0040_0000;
	always #2.5 clk_i = ~clk_i;
	brr_core_model u_core (.clk_i(clk_i), .retire_o(retire), .zero_disp_o(zdisp), .from_o(rfrom), .to_o(rto),
		.info_o(rinfo));
	brr_ctrl u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .warm_reset_i(ev[0]), .in_deep_idle_i(deep_idle),
		.debug_exception_i(ev[1]), .secure_launch_i(ev[2]), .monitor_wait_deep_i(ev[3]),
		.monitor_wait_clear_i(ev[4]), .sys_mgmt_enter_i(ev[5]), .resume_sys_mgmt_i(ev[6]),
		.perf_irq_pending_i(perf_irq), .freeze_clear_i(ev[7]), .freeze_on_perf_interrupt_i(frz_on),
		.arch_records_i(arch), .retire_i(retire), .retire_zero_disp_call_i(zdisp), .retire_from_i(rfrom),
		.retire_to_i(rto), .retire_info_i(rinfo), .wr_i(wr), .wr_sel_i(sel), .wr_idx_i(3'h0), .wr_data_i(wdat),
		.dbg_bit0_wr_i(ev[8]), .rd_idx_i(3'h0), .sample_record_config_i(cfg), .branch_record_control_o(ctl),
		.branch_record_depth_o(depth), .branch_record_freeze_o(frz), .rd_from_o(rdf), .rd_to_o(rdt),
		.rd_info_o(rdi), .ler_from_o(lerf), .dbg_bit0_o(dbg0), .record_format_code_o(fmt), .wr_fault_o(fault),
		.sample_embed_o(emb), .sampled_entry_count_o(scnt), .sample_size_o(ssize), .trace_valid_o(tv),
		.trace_from_o(tf), .trace_to_o(tt));
	// Compare one value, count it, report a mismatch
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One-cycle event strobe, then a spare edge so strobes never abut
	task automatic pulse(input logic [8:0] m);
		ev = m;
		@(negedge clk_i);
		ev = '0;
		@(negedge clk_i);
	endtask
	// Register write, then a spare edge so read-back has landed
	task automatic wreg(input logic [2:0] s, input logic [63:0] d);
		wr = 1'b1;
		sel = s;
		wdat = d;
		@(negedge clk_i);
		wr = 1'b0;
		@(negedge clk_i);
	endtask
	// Retire one branch and look at the trace store in its only valid cycle; ef and et are the copy's addresses
	task automatic rt(input logic zd, input logic exp_tv, input logic [63:0] ef, input logic [63:0] et);
		u_core.send(a_src, b_dst, zd);
		chk(tv, exp_tv);
		if (exp_tv) begin
			chk(tf, ef);
			chk(tt, et);
		end
		@(negedge clk_i);
	endtask
	// Verdict and end of run
	task automatic end_sim();
		if (n_errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(negedge clk_i);
		resetn_i = 1'b1;
		@(negedge clk_i);
		chk(depth, 64'h8);
		for (int i = 0; i < 4; i++) begin
			cfg = cfg_r[i];
			@(negedge clk_i);
			chk(emb, emb_r[i]);
			if (emb_r[i]) begin
				chk(scnt, cnt_r[i]);
			end
			chk(ssize, size_r[i]);
		end
		wreg(3'h6, 64'h1);
		rt(1'b0, 1'b1, a_can, b_dst);
		chk(rdf, a_can);
		rt(1'b1, 1'b0, a_can, b_dst);
		wreg(3'h3, a_src);
		chk(lerf, a_can);
		chk(fault, 64'h0);
		wreg(3'h2, '1);
		chk(rdi, INFO_DEF_MASK);
		wreg(3'h0, 64'h1234_0000_0000_0010);
		chk(rdf, 64'h0000_0000_0000_0010);
		pulse(9'h010);
		chk(rdf, 64'h0000_0000_0000_0010);
		pulse(9'h018);
		chk(rdf, 64'h0);
		chk(ctl, 64'h1);
		frz_on = 1'b1;
		perf_irq = 1'b1;
		@(negedge clk_i);
		perf_irq = 1'b0;
		chk(frz, 64'h1);
		rt(1'b0, 1'b0, 64'h0, 64'h0);
		chk(rdf, 64'h0);
		pulse(9'h080);
		chk(frz, 64'h0);
		ev = 9'h002;
		rt(1'b0, 1'b1, 64'h0, 64'h0);
		ev = '0;
		chk(ctl, 64'h0);
		chk(rdf, 64'h0);
		wreg(3'h6, 64'h1);
		pulse(9'h020);
		chk(ctl, 64'h0);
		pulse(9'h040);
		chk(ctl, 64'h1);
		rt(1'b0, 1'b1, a_can, b_dst);
		wreg(3'h7, 64'h4);
		cfg = 32'h0800_0008;
		@(negedge clk_i);
		chk(scnt, 64'h4);
		chk(ssize, 64'h0090);
		pulse(9'h001);
		chk(ctl, 64'h0);
		chk(depth, 64'h4);
		chk(rdf, a_can);
		wreg(3'h6, 64'h1);
		pulse(9'h004);
		chk(ctl, 64'h0);
		u_core.send(64'h0000_0000_0000_0abc, b_dst, 1'b0);
		chk(tv, 64'h1);
		chk(tf, a_can);
		repeat (2) @(negedge clk_i);
		chk(rdf, a_can);
		deep_idle = 1'b1;
		pulse(9'h001);
		deep_idle = 1'b0;
		chk(depth, 64'h8);
		chk(rdf, 64'h0);
		arch = 1'b1;
		wdat = 64'h1;
		pulse(9'h100);
		chk(dbg0, 64'h0);
		chk(fmt, 64'h3f);
		arch = 1'b0;
		repeat (2) @(negedge clk_i);
		chk(dbg0, 64'h1);
		chk(fmt, 64'h0);
		end_sim();
	end
	// Watchdog against a hung run
	initial begin
		repeat (4000) @(posedge clk_i);
		n_errors++;
		end_sim();
	end
endmodule // tb
`default_nettype wire
